// ===== verilog/operand_addr_defs.svh
// Constants for the data operand address generator.
// Contract
// - Direct operand file address is the instruction word's low byte.
// - Access-select one: bank select value joins literal into 14-bit address.
// - Access-select zero: literal selects shared access bank, bank select ignored.
// - Long-address instructions use their 14-bit address directly, bank ignored.
// - Destination-select one: result written back into the source file register.
// - Destination-select zero: result goes to working register, file unchanged.
// - Without destination field, opcode's implied destination is used.
// - Three pointer pairs of two bytes hold 14 bits; top high bits unused.
// - Three storage-less indirect operands access memory at their pointer pair.
// - Indirect variants post-increment, post-decrement or offset the pointer pair.
// - Indirect target comes only from the pointer; bank and access bit ignored.
// - Pointer bytes are mapped special registers reachable by direct instructions.
`ifndef OPERAND_ADDR_DEFS_SVH
`define OPERAND_ADDR_DEFS_SVH

// ==========================================================================
// Data memory map
`define ADDR_WIDTH          14
`define BANK_WIDTH          6
`define ACCESS_SPLIT        8'h60
`define ACCESS_LOW_BANK     6'h00
`define ACCESS_SFR_BANK     6'h3F
`define SFR_BANK_SELECT     14'h3FDC
`define SFR_PTR_BASE        14'h3FD0
`define SFR_PTR_STRIDE      14'h0004
`define SFR_PTR_LOW_OFS     14'h0000
`define SFR_PTR_HIGH_OFS    14'h0001
`define SFR_INDIRECT_OFS    14'h0002
`define POINTER_COUNT       3

// ==========================================================================
// Register bus map
`define REG_BANK_SELECT     8'h00
`define REG_POINTER_ZERO    8'h04
`define REG_POINTER_ONE     8'h08
`define REG_POINTER_TWO     8'h0C
`define REG_LAST_ACCESS     8'h10
`define LAST_INDIRECT_BIT   16
`define LAST_FILE_BIT       17
`define LAST_WORK_BIT       18
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== verilog/operand_addr_pkg.sv
// Types shared by the data operand address generator.
package operand_addr_pkg;

    // ======================================================================
    // Operand addressing kinds
    typedef enum logic [2:0] {
        OP_DIRECT   = 3'b001,
        OP_LONG     = 3'b010,
        OP_INDIRECT = 3'b100
    } op_kind_t;

    // ======================================================================
    // Indirect pointer handling modes
    typedef enum logic [4:0] {
        IND_PLAIN   = 5'b00001,
        IND_POSTINC = 5'b00010,
        IND_POSTDEC = 5'b00100,
        IND_PREINC  = 5'b01000,
        IND_OFFSET  = 5'b10000
    } ind_mode_t;

endpackage : operand_addr_pkg

// ===== verilog/pointer_update.sv
// Effective address and next pointer value for one indirect access.
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module pointer_update (
    input  wire logic [13:0]                  ptr_in,
    input  wire operand_addr_pkg::ind_mode_t  mode_in,
    input  wire logic [7:0]                   offset_in,
    output logic      [13:0]                  eff_addr_out,
    output logic      [13:0]                  next_ptr_out,
    output logic                              update_out
);

    // Adds a signed step to a pointer, wrapping over the linear space.
    function automatic logic [13:0] step14(input logic [13:0] a, input logic [13:0] b);
        logic [14:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[13:0];
    endfunction : step14

    // ======================================================================
    // Mode decode
    always_comb
    begin
        eff_addr_out = ptr_in;
        next_ptr_out = ptr_in;
        update_out   = 1'b0;
        case (mode_in)
            operand_addr_pkg::IND_PLAIN:
            begin
                update_out = 1'b0;
            end
            operand_addr_pkg::IND_POSTINC:
            begin
                next_ptr_out = step14(ptr_in, 14'h0001);
                update_out   = 1'b1;
            end
            operand_addr_pkg::IND_POSTDEC:
            begin
                next_ptr_out = step14(ptr_in, 14'h3FFF);
                update_out   = 1'b1;
            end
            operand_addr_pkg::IND_PREINC:
            begin
                eff_addr_out = step14(ptr_in, 14'h0001);
                next_ptr_out = eff_addr_out;
                update_out   = 1'b1;
            end
            operand_addr_pkg::IND_OFFSET:
            begin
                eff_addr_out = step14(ptr_in, {6'h00, offset_in});
            end
            default:
            begin
                update_out = 1'b0;
            end
        endcase
    end

endmodule : pointer_update

// ===== verilog/data_operand_address_gen.sv
// Operand address generator with pointer pairs and a register bus slave.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module data_operand_address_gen (
    input  wire logic                             CLK_IN,
    input  wire logic                             RESET_IN,
    input  wire logic                             OP_VALID_IN,
    input  wire operand_addr_pkg::op_kind_t       OP_KIND_IN,
    input  wire logic [15:0]                      INSTR_WORD_IN,
    input  wire logic                             ACCESS_SEL_IN,
    input  wire logic                             HAS_DEST_IN,
    input  wire logic                             DEST_SEL_IN,
    input  wire logic                             IMPLIED_FILE_IN,
    input  wire logic [13:0]                      LONG_ADDR_IN,
    input  wire logic [1:0]                       IND_SEL_IN,
    input  wire operand_addr_pkg::ind_mode_t      IND_MODE_IN,
    input  wire logic [7:0]                       IND_OFFSET_IN,
    input  wire logic                             SFR_WR_IN,
    input  wire logic [13:0]                      SFR_WR_ADDR_IN,
    input  wire logic [7:0]                       SFR_WR_DATA_IN,
    input  wire logic [13:0]                      SFR_RD_ADDR_IN,
    output logic      [7:0]                       SFR_RD_DATA_OUT,
    output logic                                  ADDR_VALID_OUT,
    output logic      [13:0]                      ADDR_OUT,
    output logic                                  INDIRECT_OUT,
    output logic                                  WRITE_FILE_OUT,
    output logic                                  WRITE_WORK_OUT,
    input  wire logic [7:0]                       AXI_AWADDR_IN,
    input  wire logic                             AXI_AWVALID_IN,
    output logic                                  AXI_AWREADY_OUT,
    input  wire logic [31:0]                      AXI_WDATA_IN,
    input  wire logic [3:0]                       AXI_WSTRB_IN,
    input  wire logic                             AXI_WVALID_IN,
    output logic                                  AXI_WREADY_OUT,
    output logic      [1:0]                       AXI_BRESP_OUT,
    output logic                                  AXI_BVALID_OUT,
    input  wire logic                             AXI_BREADY_IN,
    input  wire logic [7:0]                       AXI_ARADDR_IN,
    input  wire logic                             AXI_ARVALID_IN,
    output logic                                  AXI_ARREADY_OUT,
    output logic      [31:0]                      AXI_RDATA_OUT,
    output logic      [1:0]                       AXI_RRESP_OUT,
    output logic                                  AXI_RVALID_OUT,
    input  wire logic                             AXI_RREADY_IN
);

    // ======================================================================
    // Storage
    logic [5:0]                  bank_select_reg;
    logic [13:0]                 pointer_pair [0:2];
    logic [7:0]                  literal;
    logic [13:0]                 direct_addr;
    logic [13:0]                 base_addr;
    logic                        sel_ind;
    logic [1:0]                  ind_idx;
    logic [2:0]                  hit;
    operand_addr_pkg::ind_mode_t ind_mode;
    logic [13:0]                 eff_addr;
    logic [13:0]                 next_ptr;
    logic                        ptr_update;
    logic                        op_fire;
    logic                        aw_got;
    logic                        w_got;
    logic [7:0]                  aw_addr;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        axi_wr;
    logic [31:0]                 next_rdata;
    logic                        next_rerr;

    // Recognises the three indirect operand addresses: {hit, index}.
    function automatic logic [2:0] ind_hit(input logic [13:0] addr);
        logic [2:0] res;
        res = 3'h0;
        for (int n = 0; n < `POINTER_COUNT; n++)
        begin
            if (addr == `SFR_PTR_BASE + 14'(n) * `SFR_PTR_STRIDE + `SFR_INDIRECT_OFS)
            begin
                res = {1'b1, 2'(n)};
            end
        end
        return res;
    endfunction : ind_hit

    // Address of one byte of pointer pair n.
    function automatic logic [13:0] ptr_sfr(input int n, input logic [13:0] ofs);
        return `SFR_PTR_BASE + 14'(n) * `SFR_PTR_STRIDE + ofs;
    endfunction : ptr_sfr

    // ======================================================================
    // Operand address resolution
    always_comb
    begin
        literal = INSTR_WORD_IN[7:0];
        if (ACCESS_SEL_IN)
        begin
            direct_addr = {bank_select_reg, literal};
        end
        else if (literal < `ACCESS_SPLIT)
        begin
            direct_addr = {`ACCESS_LOW_BANK, literal};
        end
        else
        begin
            direct_addr = {`ACCESS_SFR_BANK, literal};
        end
        sel_ind   = 1'b0;
        ind_idx   = 2'h0;
        ind_mode  = operand_addr_pkg::IND_PLAIN;
        base_addr = direct_addr;
        hit       = 3'h0;
        case (OP_KIND_IN)
            operand_addr_pkg::OP_DIRECT:
            begin
                hit = ind_hit(direct_addr);
            end
            operand_addr_pkg::OP_LONG:
            begin
                base_addr = LONG_ADDR_IN;
                hit       = ind_hit(LONG_ADDR_IN);
            end
            operand_addr_pkg::OP_INDIRECT:
            begin
                sel_ind  = 1'b1;
                ind_idx  = IND_SEL_IN;
                ind_mode = IND_MODE_IN;
            end
            default:
            begin
                hit = 3'h0;
            end
        endcase
        if (hit[2])
        begin
            sel_ind = 1'b1;
            ind_idx = hit[1:0];
        end
    end

    pointer_update u_pointer_update (
        .ptr_in       (pointer_pair[(ind_idx == 2'h3) ? 2'h2 : ind_idx]),
        .mode_in      (ind_mode),
        .offset_in    (IND_OFFSET_IN),
        .eff_addr_out (eff_addr),
        .next_ptr_out (next_ptr),
        .update_out   (ptr_update)
    );

    // An indirect request naming a fourth pointer is dropped.
    assign op_fire = OP_VALID_IN && !(sel_ind && ind_idx == 2'h3);

    // ======================================================================
    // Operand outputs
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            ADDR_VALID_OUT <= 1'b0;
            ADDR_OUT       <= 14'h0000;
            INDIRECT_OUT   <= 1'b0;
            WRITE_FILE_OUT <= 1'b0;
            WRITE_WORK_OUT <= 1'b0;
        end
        else
        begin
            ADDR_VALID_OUT <= op_fire;
            if (op_fire)
            begin
                ADDR_OUT     <= sel_ind ? eff_addr : base_addr;
                INDIRECT_OUT <= sel_ind;
                if (HAS_DEST_IN)
                begin
                    WRITE_FILE_OUT <= DEST_SEL_IN;
                    WRITE_WORK_OUT <= !DEST_SEL_IN;
                end
                else
                begin
                    WRITE_FILE_OUT <= IMPLIED_FILE_IN;
                    WRITE_WORK_OUT <= !IMPLIED_FILE_IN;
                end
            end
        end
    end

    // ======================================================================
    // Pointer pairs and bank select
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            bank_select_reg <= 6'h00;
            for (int n = 0; n < `POINTER_COUNT; n++)
            begin
                pointer_pair[n] <= 14'h0000;
            end
        end
        else
        begin
            if (op_fire && sel_ind && ptr_update)
            begin
                pointer_pair[ind_idx] <= next_ptr;
            end
            if (SFR_WR_IN && SFR_WR_ADDR_IN == `SFR_BANK_SELECT)
            begin
                bank_select_reg <= SFR_WR_DATA_IN[5:0];
            end
            for (int n = 0; n < `POINTER_COUNT; n++)
            begin
                if (SFR_WR_IN && SFR_WR_ADDR_IN == ptr_sfr(n, `SFR_PTR_LOW_OFS))
                begin
                    pointer_pair[n][7:0] <= SFR_WR_DATA_IN;
                end
                if (SFR_WR_IN && SFR_WR_ADDR_IN == ptr_sfr(n, `SFR_PTR_HIGH_OFS))
                begin
                    pointer_pair[n][13:8] <= SFR_WR_DATA_IN[5:0];
                end
            end
            if (axi_wr && aw_addr == `REG_BANK_SELECT && w_strb[0])
            begin
                bank_select_reg <= w_data[5:0];
            end
            for (int n = 0; n < `POINTER_COUNT; n++)
            begin
                if (axi_wr && aw_addr == `REG_POINTER_ZERO + 8'(n * 4))
                begin
                    if (w_strb[0])
                    begin
                        pointer_pair[n][7:0] <= w_data[7:0];
                    end
                    if (w_strb[1])
                    begin
                        pointer_pair[n][13:8] <= w_data[13:8];
                    end
                end
            end
        end
    end

    // ======================================================================
    // Special register read port
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            SFR_RD_DATA_OUT <= 8'h00;
        end
        else
        begin
            SFR_RD_DATA_OUT <= 8'h00;
            if (SFR_RD_ADDR_IN == `SFR_BANK_SELECT)
            begin
                SFR_RD_DATA_OUT <= {2'h0, bank_select_reg};
            end
            for (int n = 0; n < `POINTER_COUNT; n++)
            begin
                if (SFR_RD_ADDR_IN == ptr_sfr(n, `SFR_PTR_LOW_OFS))
                begin
                    SFR_RD_DATA_OUT <= pointer_pair[n][7:0];
                end
                if (SFR_RD_ADDR_IN == ptr_sfr(n, `SFR_PTR_HIGH_OFS))
                begin
                    SFR_RD_DATA_OUT <= {2'h0, pointer_pair[n][13:8]};
                end
            end
        end
    end

    // ======================================================================
    // Register bus write channel
    assign AXI_AWREADY_OUT = !aw_got && !AXI_BVALID_OUT;
    assign AXI_WREADY_OUT  = !w_got && !AXI_BVALID_OUT;
    assign axi_wr          = aw_got && w_got && !AXI_BVALID_OUT;

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            aw_got         <= 1'b0;
            w_got          <= 1'b0;
            aw_addr        <= 8'h00;
            w_data         <= 32'h0000_0000;
            w_strb         <= 4'h0;
            AXI_BVALID_OUT <= 1'b0;
            AXI_BRESP_OUT  <= `RESP_OKAY;
        end
        else
        begin
            if (AXI_AWVALID_IN && AXI_AWREADY_OUT)
            begin
                aw_got  <= 1'b1;
                aw_addr <= AXI_AWADDR_IN;
            end
            if (AXI_WVALID_IN && AXI_WREADY_OUT)
            begin
                w_got  <= 1'b1;
                w_data <= AXI_WDATA_IN;
                w_strb <= AXI_WSTRB_IN;
            end
            if (axi_wr)
            begin
                aw_got         <= 1'b0;
                w_got          <= 1'b0;
                AXI_BVALID_OUT <= 1'b1;
                AXI_BRESP_OUT  <= (aw_addr <= `REG_POINTER_TWO && aw_addr[1:0] == 2'h0)
                                  ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (AXI_BVALID_OUT && AXI_BREADY_IN)
            begin
                AXI_BVALID_OUT <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Register bus read channel
    assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;

    always_comb
    begin
        next_rerr  = 1'b0;
        next_rdata = 32'h0000_0000;
        case (AXI_ARADDR_IN)
            `REG_BANK_SELECT:  next_rdata = {26'h000_0000, bank_select_reg};
            `REG_POINTER_ZERO: next_rdata = {18'h0_0000, pointer_pair[0]};
            `REG_POINTER_ONE:  next_rdata = {18'h0_0000, pointer_pair[1]};
            `REG_POINTER_TWO:  next_rdata = {18'h0_0000, pointer_pair[2]};
            `REG_LAST_ACCESS:  next_rdata = {13'h0000, WRITE_WORK_OUT, WRITE_FILE_OUT,
                                             INDIRECT_OUT, 2'h0, ADDR_OUT};
            default:           next_rerr  = 1'b1;
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            AXI_RVALID_OUT <= 1'b0;
            AXI_RDATA_OUT  <= 32'h0000_0000;
            AXI_RRESP_OUT  <= `RESP_OKAY;
        end
        else if (AXI_ARVALID_IN && AXI_ARREADY_OUT)
        begin
            AXI_RVALID_OUT <= 1'b1;
            AXI_RDATA_OUT  <= next_rdata;
            AXI_RRESP_OUT  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
        end
        else if (AXI_RREADY_IN)
        begin
            AXI_RVALID_OUT <= 1'b0;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence direct_req_s;
        OP_VALID_IN && OP_KIND_IN == operand_addr_pkg::OP_DIRECT && !hit[2];
    endsequence

    literal_low_byte_a: assert property (direct_req_s |=> ADDR_OUT[7:0] == $past(INSTR_WORD_IN[7:0]))
        else $error("direct address low byte differs from literal");
    banked_addr_a: assert property (direct_req_s and ACCESS_SEL_IN |=> ADDR_OUT[13:8] == $past(bank_select_reg))
        else $error("banked address ignores bank select");
    bank_layout_a: assert property (direct_req_s and ACCESS_SEL_IN |=> ADDR_OUT == {$past(bank_select_reg), $past(INSTR_WORD_IN[7:0])})
        else $error("banked address layout wrong");
    access_bank_a: assert property (direct_req_s and !ACCESS_SEL_IN |=> ADDR_OUT[13:8] == ((ADDR_OUT[7:0] < `ACCESS_SPLIT) ? `ACCESS_LOW_BANK : `ACCESS_SFR_BANK))
        else $error("access bank mapping wrong");
    long_addr_a: assert property (OP_VALID_IN && OP_KIND_IN == operand_addr_pkg::OP_LONG && !hit[2] |=> ADDR_VALID_OUT && ADDR_OUT == $past(LONG_ADDR_IN))
        else $error("long address not used directly");
    dest_file_a: assert property (op_fire && HAS_DEST_IN && DEST_SEL_IN |=> WRITE_FILE_OUT && !WRITE_WORK_OUT)
        else $error("result not routed to file register");
    dest_work_a: assert property (op_fire && HAS_DEST_IN && !DEST_SEL_IN |=> WRITE_WORK_OUT && !WRITE_FILE_OUT)
        else $error("result not routed to working register");
    implied_dest_a: assert property (op_fire && !HAS_DEST_IN |=> WRITE_FILE_OUT == $past(IMPLIED_FILE_IN))
        else $error("implied destination wrong");
    virtual_operand_a: assert property (OP_VALID_IN && hit[2] |=> INDIRECT_OUT && ADDR_OUT == $past(pointer_pair[hit[1:0]]))
        else $error("indirect operand not redirected to pointer");
    post_increment_a: assert property (op_fire && OP_KIND_IN == operand_addr_pkg::OP_INDIRECT && IND_MODE_IN == operand_addr_pkg::IND_POSTINC && !SFR_WR_IN && !axi_wr |=> pointer_pair[$past(IND_SEL_IN)] == 14'($past(pointer_pair[IND_SEL_IN]) + 14'h0001) && ADDR_OUT == $past(pointer_pair[IND_SEL_IN]))
        else $error("post increment wrong");
    indirect_bank_free_a: assert property (op_fire && OP_KIND_IN == operand_addr_pkg::OP_INDIRECT && IND_MODE_IN == operand_addr_pkg::IND_PLAIN |=> ADDR_OUT == $past(pointer_pair[IND_SEL_IN]) && INDIRECT_OUT)
        else $error("indirect target depends on more than pointer");

endmodule : data_operand_address_gen

// ===== testbench/far_data_memory.sv
// Data memory side model that counts file register writes made by the generator.
`timescale 1ns/1ps
module far_data_memory (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        access_in,
    input  wire logic [13:0] addr_in,
    input  wire logic        write_file_in,
    output logic      [7:0]  file_writes_out
);
    // Counts accesses that write a result into a file register.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            file_writes_out <= 8'h00;
        else if (access_in && write_file_in)
            file_writes_out <= file_writes_out + 8'h01;
    end
endmodule : far_data_memory

// ===== testbench/tb_top.sv
// Testbench for the operand address generator.
`timescale 1ns/1ps
module tb_top;
    logic CLK_IN = 0, RESET_IN = 1, OP_VALID_IN = 0, ACCESS_SEL_IN, HAS_DEST_IN, DEST_SEL_IN;
    logic IMPLIED_FILE_IN, SFR_WR_IN = 0, AXI_AWVALID_IN = 0, AXI_WVALID_IN = 0;
    logic AXI_BREADY_IN = 0, AXI_ARVALID_IN = 0, AXI_RREADY_IN = 0, ADDR_VALID_OUT;
    logic INDIRECT_OUT, WRITE_FILE_OUT, WRITE_WORK_OUT, AXI_AWREADY_OUT, AXI_WREADY_OUT;
    logic AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT, aw, w, v;
    operand_addr_pkg::op_kind_t  OP_KIND_IN;
    operand_addr_pkg::ind_mode_t IND_MODE_IN;
    logic [15:0] INSTR_WORD_IN;
    logic [13:0] LONG_ADDR_IN, SFR_WR_ADDR_IN, SFR_RD_ADDR_IN = 0, ADDR_OUT;
    logic [7:0]  IND_OFFSET_IN = 0, SFR_WR_DATA_IN, SFR_RD_DATA_OUT, AXI_AWADDR_IN = 0;
    logic [7:0]  AXI_ARADDR_IN = 0, file_writes;
    logic [1:0]  IND_SEL_IN, AXI_BRESP_OUT, AXI_RRESP_OUT, r;
    logic [3:0]  AXI_WSTRB_IN = 4'hF;
    logic [31:0] AXI_WDATA_IN = 0, AXI_RDATA_OUT, rd;
    int num_errors = 0, comparisons = 0;
    data_operand_address_gen i_dut (.CLK_IN, .RESET_IN, .OP_VALID_IN, .OP_KIND_IN,
        .INSTR_WORD_IN, .ACCESS_SEL_IN, .HAS_DEST_IN, .DEST_SEL_IN, .IMPLIED_FILE_IN,
        .LONG_ADDR_IN, .IND_SEL_IN, .IND_MODE_IN, .IND_OFFSET_IN, .SFR_WR_IN, .SFR_WR_ADDR_IN,
        .SFR_WR_DATA_IN, .SFR_RD_ADDR_IN, .SFR_RD_DATA_OUT, .ADDR_VALID_OUT, .ADDR_OUT,
        .INDIRECT_OUT, .WRITE_FILE_OUT, .WRITE_WORK_OUT, .AXI_AWADDR_IN, .AXI_AWVALID_IN,
        .AXI_AWREADY_OUT, .AXI_WDATA_IN, .AXI_WSTRB_IN, .AXI_WVALID_IN, .AXI_WREADY_OUT,
        .AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARADDR_IN, .AXI_ARVALID_IN,
        .AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RRESP_OUT, .AXI_RVALID_OUT, .AXI_RREADY_IN);
    far_data_memory i_mem (.clk_in(CLK_IN), .reset_in(RESET_IN), .access_in(ADDR_VALID_OUT),
        .addr_in(ADDR_OUT), .write_file_in(WRITE_FILE_OUT), .file_writes_out(file_writes));
    always #20 CLK_IN = ~CLK_IN;
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic test_done;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Register bus write; the response is judged against the expected code.
    task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
        AXI_AWADDR_IN <= a;
        AXI_WDATA_IN <= d;
        AXI_AWVALID_IN <= 1;
        AXI_WVALID_IN <= 1;
        AXI_BREADY_IN <= 1;
        for (int n = 0; n < 20; n++)
        begin
            #1 aw = AXI_AWVALID_IN & AXI_AWREADY_OUT;
            w = AXI_WVALID_IN & AXI_WREADY_OUT;
            v = AXI_BVALID_OUT;
            r = AXI_BRESP_OUT;
            @(posedge CLK_IN);
            if (aw) AXI_AWVALID_IN <= 0;
            if (w) AXI_WVALID_IN <= 0;
            if (v === 1)
            begin
                AXI_BREADY_IN <= 0;
                check("bresp", resp, r);
                return;
            end
        end
        num_errors++;
        test_done();
    endtask : axi_wr
    task automatic axi_rd(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
        AXI_ARADDR_IN <= a;
        AXI_ARVALID_IN <= 1;
        AXI_RREADY_IN <= 1;
        for (int n = 0; n < 20; n++)
        begin
            #1 aw = AXI_ARVALID_IN & AXI_ARREADY_OUT;
            v = AXI_RVALID_OUT;
            r = AXI_RRESP_OUT;
            rd = AXI_RDATA_OUT;
            @(posedge CLK_IN);
            if (aw) AXI_ARVALID_IN <= 0;
            if (v === 1)
            begin
                AXI_RREADY_IN <= 0;
                check("rresp", resp, r);
                check("rdata", d, rd);
                return;
            end
        end
        num_errors++;
        test_done();
    endtask : axi_rd
    // One operand request, judged 1 ns after the clock edge that takes it.
    task automatic op(operand_addr_pkg::op_kind_t k, logic [15:0] wd, logic a, hd, d,
                      logic [1:0] sel, operand_addr_pkg::ind_mode_t m, logic [13:0] ea,
                      logic ind, vld);
        OP_VALID_IN <= 1;
        OP_KIND_IN <= k;
        INSTR_WORD_IN <= wd;
        ACCESS_SEL_IN <= a;
        HAS_DEST_IN <= hd;
        DEST_SEL_IN <= d;
        IMPLIED_FILE_IN <= d;
        LONG_ADDR_IN <= ea;
        IND_SEL_IN <= sel;
        IND_MODE_IN <= m;
        @(posedge CLK_IN);
        OP_VALID_IN <= 0;
        #1 check("addr_valid", vld, ADDR_VALID_OUT);
        if (vld) check("addr", {ind, d, ~d, ea}, {INDIRECT_OUT, WRITE_FILE_OUT, WRITE_WORK_OUT,
                                                 ADDR_OUT});
        @(posedge CLK_IN);
    endtask : op
    task automatic sfr_wr(logic [13:0] a, logic [7:0] d);
        SFR_WR_IN <= 1;
        SFR_WR_ADDR_IN <= a;
        SFR_WR_DATA_IN <= d;
        SFR_RD_ADDR_IN <= a;
        @(posedge CLK_IN);
        SFR_WR_IN <= 0;
        @(posedge CLK_IN);
    endtask : sfr_wr
    task automatic direct_cases;
        axi_wr(8'h00, 32'h0000_0005, 2'h0);
        axi_rd(8'h00, 32'h0000_0005, 2'h0);
        op(operand_addr_pkg::OP_DIRECT, 16'h6A34, 1, 1, 1, 0, IND_MODE_IN, 14'h0534, 0, 1);
        op(operand_addr_pkg::OP_DIRECT, 16'h6A20, 0, 1, 0, 0, IND_MODE_IN, 14'h0020, 0, 1);
        op(operand_addr_pkg::OP_DIRECT, 16'h0070, 0, 1, 0, 0, IND_MODE_IN, 14'h3F70, 0, 1);
        op(operand_addr_pkg::OP_LONG, 16'h0000, 1, 0, 0, 0, IND_MODE_IN, 14'h1234, 0, 1);
        op(operand_addr_pkg::OP_LONG, 16'h0000, 1, 0, 1, 0, IND_MODE_IN, 14'h2ABC, 0, 1);
        #1 check("file_writes", 8'h02, file_writes);
        axi_wr(8'h10, 32'h0000_0001, 2'h2);
        axi_rd(8'h14, 32'h0000_0000, 2'h2);
    endtask : direct_cases
    task automatic pointer_cases;
        sfr_wr(14'h3FD4, 8'hFF);
        sfr_wr(14'h3FD5, 8'hFF);
        #1 check("ptr_high", 8'h3F, SFR_RD_DATA_OUT);
        @(posedge CLK_IN);
        axi_rd(8'h08, 32'h0000_3FFF, 2'h0);
        op(operand_addr_pkg::OP_INDIRECT, 0, 1, 1, 0, 1, operand_addr_pkg::IND_POSTINC, 14'h3FFF, 1, 1);
        op(operand_addr_pkg::OP_INDIRECT, 0, 0, 1, 0, 1, operand_addr_pkg::IND_POSTDEC, 14'h0000, 1, 1);
        IND_OFFSET_IN <= 8'h10;
        op(operand_addr_pkg::OP_INDIRECT, 0, 0, 1, 0, 1, operand_addr_pkg::IND_OFFSET, 14'h000F, 1, 1);
        op(operand_addr_pkg::OP_INDIRECT, 0, 0, 1, 0, 1, operand_addr_pkg::IND_PREINC, 14'h0000, 1, 1);
        op(operand_addr_pkg::OP_INDIRECT, 0, 0, 1, 0, 3, operand_addr_pkg::IND_PLAIN, 14'h0000, 1, 0);
        op(operand_addr_pkg::OP_INDIRECT, 0, 1, 1, 0, 2, operand_addr_pkg::IND_PLAIN, 14'h0000, 1, 1);
        op(operand_addr_pkg::OP_DIRECT, 16'h00D6, 0, 1, 1, 0, IND_MODE_IN, 14'h0000, 1, 1);
    endtask : pointer_cases
    initial
    begin
        repeat (5) @(posedge CLK_IN);
        RESET_IN <= 0;
        @(posedge CLK_IN);
        direct_cases();
        pointer_cases();
        test_done();
    end
endmodule : tb_top
